// File: pkg/tcs_pkg.sv
package tcs_pkg;

   // Frequency select codes of the transmit clock input.
   localparam logic [2:0] TCS_FREQ_X1 = 3'h0;
   localparam logic [2:0] TCS_FREQ_X2 = 3'h1;
   localparam logic [2:0] TCS_FREQ_X4 = 3'h2;
   localparam logic [2:0] TCS_FREQ_X8 = 3'h3;
   localparam logic [2:0] TCS_FREQ_X16 = 3'h4;

   // System clock rate and the base reference rates, in kHz.
   localparam int TCS_SYS_KHZ = 200000;
   localparam int TCS_E1_BASE_KHZ = 2048;
   localparam int TCS_T1_BASE_KHZ = 1544;

   // Cycles of the system clock in one slowest reference period, rounded up.
   localparam int TCS_REF_PERIOD_CYC =
      (TCS_SYS_KHZ + TCS_T1_BASE_KHZ - 1) / TCS_T1_BASE_KHZ;

   // Missing periods that count as a regulation event or as loss.
   localparam logic [2:0] TCS_LOSS_PERIODS = 3'h4;
   localparam int TCS_CNT_W = 12;
   localparam logic [TCS_CNT_W-1:0] TCS_PERIOD_CNT =
      TCS_CNT_W'(TCS_REF_PERIOD_CYC);

   // Edges of a returning clock needed before it is active again.
   localparam logic [2:0] TCS_RECOVER_EDGES = 3'h4;

   // Oscillator behaviour on reference loss.
   typedef enum logic [2:0] {
      TCS_OSC_TRACK = 3'b001,
      TCS_OSC_CENTRE = 3'b010,
      TCS_OSC_FREEZE = 3'b100
   } tcs_osc_state_t;

   // Reset values.
   localparam logic TCS_RST_SRC_DIRECT = 1'b1;
   localparam logic TCS_RST_REF_INPUT = 1'b1;

endpackage : tcs_pkg

// File: hw/tcs_clock_monitor.sv
`timescale 1ns/100ps
// Watches a synchronised clock level and reports its loss and recovery.
module tcs_clock_monitor
   import tcs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic clk_sync_i,
   output logic rise_o,
   output logic miss_o,
   output logic lost_o
);

   logic last_q;
   logic [TCS_CNT_W-1:0] gap_q;
   logic [2:0] miss_cnt_q;
   logic [2:0] edge_cnt_q;
   logic rise;

   assign rise = clk_sync_i & ~last_q;

   ////////////////////////////////////////////////////////////////////////
   // Edge finder on the already synchronised level.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         last_q <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         last_q <= clk_sync_i;
         rise_o <= rise;
      end
   end

   // Each period without an edge counts one missing period.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         gap_q <= '0;
         miss_cnt_q <= '0;
         miss_o <= 1'b0;
      end else begin
         miss_o <= 1'b0;
         if (rise) begin
            gap_q <= '0;
            miss_cnt_q <= '0;
         end else if (gap_q == TCS_PERIOD_CNT) begin
            gap_q <= '0;
            miss_o <= 1'b1;
            if (miss_cnt_q != TCS_LOSS_PERIODS) begin
               miss_cnt_q <= miss_cnt_q + 3'h1;
            end
         end else begin
            gap_q <= gap_q + TCS_CNT_W'(1);
         end
      end
   end

   // Loss after four missing periods, recovery after a run of edges.
   // The edge run keeps a single glitch from ending a loss.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         lost_o <= 1'b1;
         edge_cnt_q <= '0;
      end else if (!lost_o) begin
         edge_cnt_q <= '0;
         if (gap_q == TCS_PERIOD_CNT && !rise &&
             miss_cnt_q == TCS_LOSS_PERIODS - 3'h1) begin
            lost_o <= 1'b1;
         end
      end else if (miss_o) begin
         edge_cnt_q <= '0;
      end else if (rise) begin
         if (edge_cnt_q == TCS_RECOVER_EDGES - 3'h1) begin
            lost_o <= 1'b0;
         end else begin
            edge_cnt_q <= edge_cnt_q + 3'h1;
         end
      end
   end

endmodule : tcs_clock_monitor

// File: hw/tcs_line_coder.sv
`timescale 1ns/100ps
// Line coder: AMI or B8ZS ternary, or CMI optical with optional precoding.
module tcs_line_coder
   import tcs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic bit_en_i,
   input wire logic half_en_i,
   input wire logic data_i,
   input wire logic optical_i,
   input wire logic b8zs_i,
   input wire logic cmi_precode_disable_i,
   input wire logic cmi_precode_type_i,
   output logic pos_o,
   output logic neg_o,
   output logic cmi_o
);

   logic [7:0] hist_q;
   logic last_pol_q;
   logic [1:0] zero_run_q;
   logic cmi_pol_q;
   logic cmi_second_q;
   logic cur_bit_q;
   logic mark;

   // A full window of eight zeros forces the substitution pattern.
   logic sub_hit;
   logic cmi_one;
   assign sub_hit = b8zs_i && (hist_q[6:0] == 7'h00) && !data_i;
   assign mark = sub_hit ? 1'b0 : data_i;
   assign cmi_one = cmi_precode_disable_i ? data_i :
      (data_i | (cmi_precode_type_i ? zero_run_q == 2'h3 : sub_hit));

   ////////////////////////////////////////////////////////////////////////
   // Ternary mark generation, alternating polarity per mark.
   // Substitution is simplified to flagging violations on the eighth zero.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         hist_q <= '0;
         last_pol_q <= 1'b0;
         pos_o <= 1'b0;
         neg_o <= 1'b0;
         zero_run_q <= '0;
      end else if (bit_en_i) begin
         hist_q <= {hist_q[6:0], data_i};
         if (sub_hit) begin
            pos_o <= last_pol_q; // Bipolar violation marker.
            neg_o <= ~last_pol_q;
            hist_q <= '0;
         end else if (mark) begin
            pos_o <= ~last_pol_q;
            neg_o <= last_pol_q;
            last_pol_q <= ~last_pol_q;
         end else begin
            pos_o <= 1'b0;
            neg_o <= 1'b0;
         end
         zero_run_q <= data_i ? 2'h0 : zero_run_q + {1'b0, zero_run_q != 2'h3};
      end
   end

   // CMI: a one alternates constant levels, a zero is low then high.
   // Precoding folds a violation in by an extra polarity flip.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         cmi_pol_q <= 1'b0;
         cmi_second_q <= 1'b0;
         cur_bit_q <= 1'b0;
         cmi_o <= 1'b0;
      end else if (!optical_i) begin
         cmi_o <= 1'b0;
         cmi_second_q <= 1'b0;
      end else if (bit_en_i) begin
         cur_bit_q <= cmi_one;
         cmi_second_q <= 1'b0;
         if (cmi_one) begin
            cmi_o <= ~cmi_pol_q;
            cmi_pol_q <= ~cmi_pol_q;
         end else begin
            cmi_o <= 1'b0;
         end
      end else if (half_en_i && !cmi_second_q) begin
         cmi_second_q <= 1'b1;
         if (!cur_bit_q) begin
            cmi_o <= 1'b1;
         end
      end
   end

endmodule : tcs_line_coder

// File: hw/tcs_tx_clock_switch.sv
`timescale 1ns/100ps
// What this block does
// - Input clock rate chosen by a 3-bit field.
// - Output clock may come from the oscillator, input as reference.
// - With auto-switch on, framer clock replaces a lost input clock.
// - Direct path: on input loss move output to the oscillator.
// - Return output to the input clock once it is active again.
// - Each output source switch sets a maskable status flag.
// - Switching can jump phase; output may vanish during detection.
// - Clearing auto-switch forces the direct input and sets the flag.
// - Oscillator path: on input loss move reference to framer clock.
// - Move reference back to input clock once it is active.
// - Each reference switch sets its own maskable status flag.
// - Clearing auto-switch restores input reference and sets its flag.
// - Two live bits show loss of input and framer clocks.
// - Ternary output converts single-rail data with AMI or B8ZS.
// - Optical output is CMI, optionally precoded; polarity select applies to the output clock only.
// - Series resistance select: 1 for E1, 0 for T1/J1.
// - One to three missing periods regulate; four or more is loss.
module tcs_tx_clock_switch
   import tcs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic tx_clock_input_i,
   input wire logic framer_tx_clock_i,
   input wire logic tx_data_i,
   input wire logic e1_mode_i,
   input wire logic [2:0] tx_input_freq_select_i,
   input wire logic use_oscillator_i,
   input wire logic auto_tx_clock_switch_en_i,
   input wire logic oscillator_centre_en_i,
   input wire logic output_clock_switch_mask_i,
   input wire logic reference_switch_mask_i,
   input wire logic output_clock_switch_clear_i,
   input wire logic reference_switch_clear_i,
   input wire logic series_resistance_select_i,
   input wire logic tx_coding_select_a_i,
   input wire logic dual_rail_select_i,
   input wire logic b8zs_en_i,
   input wire logic cmi_precode_disable_i,
   input wire logic cmi_precode_type_i,
   input wire logic output_clock_polarity_i,
   output logic tx_output_clock_o,
   output logic output_clock_from_osc_o,
   output logic reference_is_framer_o,
   output logic output_clock_switch_flag_o,
   output logic reference_switch_flag_o,
   output logic output_clock_switch_irq_o,
   output logic reference_switch_irq_o,
   output logic tx_input_clock_lost_o,
   output logic framer_tx_clock_lost_o,
   output logic osc_regulating_o,
   output logic osc_centred_o,
   output logic osc_frozen_o,
   output logic line_mode_e1_o,
   output logic line_out_a_o,
   output logic line_out_b_o,
   output logic optical_data_out_o
);

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for both external clocks.
   logic tin_s1_q, tin_s2_q, fck_s1_q, fck_s2_q;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         tin_s1_q <= 1'b0;
         tin_s2_q <= 1'b0;
         fck_s1_q <= 1'b0;
         fck_s2_q <= 1'b0;
      end else begin
         tin_s1_q <= tx_clock_input_i;
         tin_s2_q <= tin_s1_q;
         fck_s1_q <= framer_tx_clock_i;
         fck_s2_q <= fck_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock monitors.
   logic tin_rise, tin_miss, tin_lost, fck_rise, fck_miss, fck_lost;

   tcs_clock_monitor u_tin_mon (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .clk_sync_i(tin_s2_q),
      .rise_o(tin_rise),
      .miss_o(tin_miss),
      .lost_o(tin_lost)
   );

   tcs_clock_monitor u_fck_mon (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .clk_sync_i(fck_s2_q),
      .rise_o(fck_rise),
      .miss_o(fck_miss),
      .lost_o(fck_lost)
   );

   ////////////////////////////////////////////////////////////////////////
   // Input divider: a fast input is cut down to the base line rate.
   logic [3:0] div_q;
   logic [3:0] div_last;
   logic tin_base_en;

   always_comb begin
      unique case (tx_input_freq_select_i)
         TCS_FREQ_X2: div_last = 4'h1;
         TCS_FREQ_X4: div_last = 4'h3;
         TCS_FREQ_X8: div_last = 4'h7;
         TCS_FREQ_X16: div_last = 4'hf;
         default: div_last = 4'h0; // Base rate and unused codes.
      endcase
   end

   assign tin_base_en = tin_rise && (div_q == div_last);

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         div_q <= '0;
      end else if (tin_rise) begin
         div_q <= (div_q >= div_last) ? 4'h0 : div_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Source selection; the direct path trusts the input rate unchecked.
   logic src_direct_q;
   logic ref_input_q;
   logic auto_q;
   logic src_direct_d;
   logic ref_input_d;

   always_comb begin
      src_direct_d = src_direct_q;
      ref_input_d = ref_input_q;
      if (!auto_tx_clock_switch_en_i) begin
         src_direct_d = 1'b1;
         ref_input_d = 1'b1;
      end else if (!use_oscillator_i) begin
         // Direct path relies on the input divided down to the base rate.
         src_direct_d = ~tin_lost;
         ref_input_d = 1'b1;
      end else begin
         src_direct_d = 1'b0;
         ref_input_d = ~tin_lost;
      end
      if (!auto_tx_clock_switch_en_i && use_oscillator_i) begin
         src_direct_d = 1'b0;
      end
   end

   // Flag on every source change, and on disabling auto-switch.
   // Set wins over a clear arriving in the same cycle.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         src_direct_q <= TCS_RST_SRC_DIRECT;
         ref_input_q <= TCS_RST_REF_INPUT;
         auto_q <= 1'b0;
         output_clock_switch_flag_o <= 1'b0;
         reference_switch_flag_o <= 1'b0;
      end else begin
         src_direct_q <= src_direct_d;
         ref_input_q <= ref_input_d;
         auto_q <= auto_tx_clock_switch_en_i;
         if ((src_direct_d != src_direct_q) ||
             (auto_q && !auto_tx_clock_switch_en_i)) begin
            output_clock_switch_flag_o <= 1'b1;
         end else if (output_clock_switch_clear_i) begin
            output_clock_switch_flag_o <= 1'b0;
         end
         if ((ref_input_d != ref_input_q) ||
             (auto_q && !auto_tx_clock_switch_en_i)) begin
            reference_switch_flag_o <= 1'b1;
         end else if (reference_switch_clear_i) begin
            reference_switch_flag_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Oscillator: follows its reference edges; on loss it centres or freezes.
   // It cannot run faster than its reference edges here, so centring is
   // modelled as a free run at the nominal base period.
   tcs_osc_state_t osc_q;
   logic [TCS_CNT_W-1:0] osc_cnt_q;
   logic [TCS_CNT_W-1:0] osc_period_q;
   logic osc_tick;
   logic ref_edge;
   logic ref_miss;
   logic ref_lost;

   // Direct path with auto-switch references the oscillator to the framer.
   assign ref_edge = (ref_input_q && use_oscillator_i) ? tin_base_en
                                                       : fck_rise;
   assign ref_miss = (ref_input_q && use_oscillator_i) ? tin_miss : fck_miss;
   assign ref_lost = (ref_input_q && use_oscillator_i) ? tin_lost : fck_lost;
   assign osc_tick = (osc_q == TCS_OSC_TRACK) ? ref_edge :
      (osc_q == TCS_OSC_CENTRE) ? (osc_cnt_q == TCS_PERIOD_CNT) :
      (osc_cnt_q == osc_period_q);

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         osc_q <= TCS_OSC_TRACK;
         osc_cnt_q <= '0;
         osc_period_q <= TCS_PERIOD_CNT;
         osc_regulating_o <= 1'b0;
      end else begin
         osc_cnt_q <= osc_tick ? '0 : osc_cnt_q + TCS_CNT_W'(1);
         osc_regulating_o <= ref_miss && !ref_lost;
         if (osc_q == TCS_OSC_TRACK && ref_edge) begin
            osc_period_q <= osc_cnt_q;
         end
         unique case (osc_q)
            TCS_OSC_TRACK: begin
               if (ref_lost) begin
                  osc_q <= oscillator_centre_en_i ? TCS_OSC_CENTRE
                                                  : TCS_OSC_FREEZE;
               end
            end
            TCS_OSC_CENTRE, TCS_OSC_FREEZE: begin
               if (!ref_lost) begin
                  osc_q <= TCS_OSC_TRACK;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output clock: rises on each selected tick. During loss detection the
   // direct path stops, so the clock gaps.
   logic out_clk_q;
   logic bit_en;
   logic half_en;
   logic [TCS_CNT_W-1:0] half_cnt_q;

   assign bit_en = src_direct_q ? tin_base_en : osc_tick;
   assign half_en = (half_cnt_q == (osc_period_q >> 1));

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         out_clk_q <= 1'b0;
         half_cnt_q <= '0;
         tx_output_clock_o <= 1'b0;
      end else begin
         half_cnt_q <= bit_en ? '0 : half_cnt_q + TCS_CNT_W'(1);
         if (bit_en) begin
            out_clk_q <= 1'b1;
         end else if (half_en) begin
            out_clk_q <= 1'b0;
         end
         tx_output_clock_o <= out_clk_q ^ output_clock_polarity_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line coding and plain status outputs.
   logic optical;
   logic pos, neg, cmi;

   assign optical = !tx_coding_select_a_i && dual_rail_select_i;

   tcs_line_coder u_coder (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .bit_en_i(bit_en),
      .half_en_i(half_en),
      .data_i(tx_data_i),
      .optical_i(optical),
      .b8zs_i(b8zs_en_i),
      .cmi_precode_disable_i(cmi_precode_disable_i),
      .cmi_precode_type_i(cmi_precode_type_i),
      .pos_o(pos),
      .neg_o(neg),
      .cmi_o(cmi)
   );

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         output_clock_from_osc_o <= 1'b0;
         reference_is_framer_o <= 1'b0;
         output_clock_switch_irq_o <= 1'b0;
         reference_switch_irq_o <= 1'b0;
         tx_input_clock_lost_o <= 1'b1;
         framer_tx_clock_lost_o <= 1'b1;
         osc_centred_o <= 1'b0;
         osc_frozen_o <= 1'b0;
         line_mode_e1_o <= 1'b0;
         line_out_a_o <= 1'b0;
         line_out_b_o <= 1'b0;
         optical_data_out_o <= 1'b0;
      end else begin
         output_clock_from_osc_o <= ~src_direct_q;
         reference_is_framer_o <= ~ref_input_q;
         output_clock_switch_irq_o <= output_clock_switch_flag_o &
                                      ~output_clock_switch_mask_i;
         reference_switch_irq_o <= reference_switch_flag_o &
                                   ~reference_switch_mask_i;
         tx_input_clock_lost_o <= tin_lost;
         framer_tx_clock_lost_o <= fck_lost;
         osc_centred_o <= (osc_q == TCS_OSC_CENTRE);
         osc_frozen_o <= (osc_q == TCS_OSC_FREEZE);
         line_mode_e1_o <= series_resistance_select_i;
         line_out_a_o <= optical ? 1'b0 : pos;
         line_out_b_o <= optical ? 1'b0 : neg;
         optical_data_out_o <= optical ? cmi : 1'b0;
      end
   end

endmodule : tcs_tx_clock_switch

// File: verification/tcs_tx_clock_switch_monitor.sv
`timescale 1ns/100ps
// Port-level checks on the transmit clock switch.
module tcs_tx_clock_switch_monitor (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic tx_clock_input_i,
   input wire logic use_oscillator_i,
   input wire logic auto_tx_clock_switch_en_i,
   input wire logic output_clock_switch_mask_i,
   input wire logic reference_switch_mask_i,
   input wire logic output_clock_from_osc_o,
   input wire logic reference_is_framer_o,
   input wire logic output_clock_switch_flag_o,
   input wire logic reference_switch_flag_o,
   input wire logic output_clock_switch_irq_o,
   input wire logic reference_switch_irq_o,
   input wire logic tx_input_clock_lost_o
);
   // Short aliases keep the properties readable.
   wire lost = tx_input_clock_lost_o;
   wire src = output_clock_from_osc_o;
   wire rfr = reference_is_framer_o;
   wire ocf = output_clock_switch_flag_o;
   wire rff = reference_switch_flag_o;
   wire osc = use_oscillator_i;
   wire auto_on = auto_tx_clock_switch_en_i;
   logic prev_q;
   logic [9:0] idle_q;

   // Cycles since the input clock moved; saturates so it never wraps.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         prev_q <= 1'b0;
         idle_q <= 10'h000;
      end else begin
         prev_q <= tx_clock_input_i;
         if (prev_q != tx_clock_input_i) begin
            idle_q <= 10'h000;
         end else if (idle_q != 10'h3ff) begin
            idle_q <= idle_q + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   // Loss and recovery with auto-switch on, and auto-switch off for three cycles.
   sequence s_loss_auto;
      $rose(lost) && auto_on;
   endsequence
   sequence s_back_auto;
      $fell(lost) && auto_on;
   endsequence
   sequence s_auto_off;
      !auto_on [*3];
   endsequence

   property p_src_to_osc;
      s_loss_auto ##0 !osc |=> src;
   endproperty
   a_src_to_osc: assert property (p_src_to_osc)
      else $error("no move to oscillator");
   property p_ref_to_framer;
      s_loss_auto ##0 osc |=> rfr;
   endproperty
   a_ref_to_framer: assert property (p_ref_to_framer)
      else $error("no move to framer reference");
   property p_src_back;
      s_back_auto ##0 !osc |=> !src;
   endproperty
   a_src_back: assert property (p_src_back)
      else $error("no return to input");
   property p_ref_back;
      s_back_auto ##0 osc |=> !rfr;
   endproperty
   a_ref_back: assert property (p_ref_back)
      else $error("no reference return");
   property p_src_flag;
      $rose(src) && !osc |-> ocf;
   endproperty
   a_src_flag: assert property (p_src_flag)
      else $error("switch without flag");
   property p_ref_flag;
      $changed(rfr) && osc && $past(osc, 2) |-> rff;
   endproperty
   a_ref_flag: assert property (p_ref_flag)
      else $error("reference switch without flag");
   property p_irq_oc;
      output_clock_switch_irq_o ==
         ($past(ocf) && !$past(output_clock_switch_mask_i));
   endproperty
   a_irq_oc: assert property (p_irq_oc)
      else $error("bad output switch irq");
   property p_irq_rf;
      reference_switch_irq_o ==
         ($past(rff) && !$past(reference_switch_mask_i));
   endproperty
   a_irq_rf: assert property (p_irq_rf)
      else $error("bad reference irq");
   property p_off_src;
      (!auto_on && !osc) [*3] |-> !src;
   endproperty
   a_off_src: assert property (p_off_src)
      else $error("input not forced");
   property p_off_ref;
      s_auto_off |-> !rfr;
   endproperty
   a_off_ref: assert property (p_off_ref)
      else $error("reference not restored");
   property p_lost_late;
      $rose(lost) |-> idle_q > 10'h190;
   endproperty
   a_lost_late: assert property (p_lost_late)
      else $error("loss too early");
   property p_lost_bound;
      idle_q == 10'h258 |-> lost;
   endproperty
   a_lost_bound: assert property (p_lost_bound)
      else $error("loss too late");
endmodule : tcs_tx_clock_switch_monitor

bind tcs_tx_clock_switch tcs_tx_clock_switch_monitor u_mon (.*);

// File: verification/tcs_framer_model.sv
`timescale 1ns/100ps
// Framer side: transmit clock input, framer clock and transmit data.
module tcs_framer_model (
   input wire logic tx_run_i,
   input wire logic framer_run_i,
   input wire logic data_i,
   output logic tx_clock_o,
   output logic framer_clock_o,
   output logic tx_data_o
);
   // A stopped clock stands low; odd offsets keep it off clock edges.
   initial begin
      tx_clock_o = 1'b0;
      #1.3;
      forever begin
         #62.5;
         tx_clock_o = tx_run_i ? ~tx_clock_o : 1'b0;
      end
   end
   initial begin
      framer_clock_o = 1'b0;
      #0.7;
      forever begin
         #61.0;
         framer_clock_o = framer_run_i ? ~framer_clock_o : 1'b0;
      end
   end
   // The framer keeps its elastic buffer in use, so data is steady.
   assign tx_data_o = data_i;
endmodule : tcs_framer_model

// File: verification/tb_tcs_tx_clock_switch.sv
`timescale 1ns/100ps
// Self-checking bench for the transmit clock switch.
module tb_tcs_tx_clock_switch
   import tcs_pkg::*;
;
   typedef struct packed {
      logic osc;
      logic srs;
      logic msk;
      logic [2:0] freq;
      logic ocf;
      logic rff;
   } tcs_row_t;
   tcs_row_t rows [2] = '{'{1'b0, 1'b1, 1'b0, TCS_FREQ_X16, 1'b1, 1'b0},
                          '{1'b1, 1'b0, 1'b1, TCS_FREQ_X1, 1'b0, 1'b1}};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic tx_run, fr_run, data, osc, auto_on, centre, msk, clr, srs, xck, sc;
   logic code_a, dual, tx_clock_input, fclk, tdat, src, rfr, ocf, rff, oci, rfi;
   logic tlost, flost, reg_p, cen, frz, e1, la, lb, opt, sa, sb, so, sr;
   logic [2:0] freq;
   int bad_count = 0;
   int check_count = 0;

   // Free-running clock.
   always #2.5 clk = ~clk;

   tcs_framer_model u_framer (.tx_run_i(tx_run), .framer_run_i(fr_run),
      .data_i(data), .tx_clock_o(tx_clock_input), .framer_clock_o(fclk),
      .tx_data_o(tdat));

   tcs_tx_clock_switch DUT (.clock_i(clk), .rstn_i(rstn),
      .tx_clock_input_i(tx_clock_input), .framer_tx_clock_i(fclk), .tx_data_i(tdat),
      .e1_mode_i(1'b1), .tx_input_freq_select_i(freq),
      .use_oscillator_i(osc), .auto_tx_clock_switch_en_i(auto_on),
      .oscillator_centre_en_i(centre), .output_clock_switch_mask_i(msk),
      .reference_switch_mask_i(msk), .output_clock_switch_clear_i(clr),
      .reference_switch_clear_i(clr), .series_resistance_select_i(srs),
      .tx_coding_select_a_i(code_a), .dual_rail_select_i(dual),
      .b8zs_en_i(1'b0), .cmi_precode_disable_i(1'b1),
      .cmi_precode_type_i(1'b0), .output_clock_polarity_i(1'b0),
      .tx_output_clock_o(xck), .output_clock_from_osc_o(src),
      .reference_is_framer_o(rfr), .output_clock_switch_flag_o(ocf),
      .reference_switch_flag_o(rff), .output_clock_switch_irq_o(oci),
      .reference_switch_irq_o(rfi), .tx_input_clock_lost_o(tlost),
      .framer_tx_clock_lost_o(flost), .osc_regulating_o(reg_p),
      .osc_centred_o(cen), .osc_frozen_o(frz), .line_mode_e1_o(e1),
      .line_out_a_o(la), .line_out_b_o(lb), .optical_data_out_o(opt));

   ////////////////////////////////////////////////////////////////////////
   // One comparison.
   task automatic chk(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Prints counts and verdict; ends the run.
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // Bounded wait on a level.
   task automatic wait_for(ref logic s, input logic v);
      int i;
      for (i = 0; i < 2000 && s !== v; i++) begin
         @(negedge clk);
      end
      if (s !== v) begin
         bad_count++;
         test_done();
      end else begin
         cyc(3);
      end
   endtask : wait_for

   // Clear pulses go out only between events, since a set would win.
   task automatic clear_flags;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
   endtask : clear_flags

   // Records which outputs moved.
   task automatic watch(input int n);
      logic last;
      last = opt;
      {sa, sb, so, sr, sc} = 5'h00;
      repeat (n) begin
         @(negedge clk);
         {sa, sb, sr, sc} = {sa | la, sb | lb, sr | reg_p, sc | xck};
         so = so | (opt != last);
         last = opt;
      end
   endtask : watch

   ////////////////////////////////////////////////////////////////////////
   // Reset, the table of cases, then edge cases.
   initial begin
      {data, osc, centre, msk, clr, srs, code_a, dual} = 8'h02;
      {tx_run, fr_run, auto_on} = 3'h7;
      freq = TCS_FREQ_X16;
      cyc(16);
      chk(tlost, 1'b1);
      chk(ocf | rff | src, 1'b0);
      rstn = 1'b1;
      wait_for(tlost, 1'b0);
      wait_for(flost, 1'b0);
      foreach (rows[k]) begin
         {osc, srs, msk, freq} = rows[k][7:2];
         cyc(20);
         clear_flags();
         tx_run = 1'b0;
         wait_for(tlost, 1'b1);
         chk(src, 1'b1);
         chk(rfr, rows[k].osc);
         chk(ocf, rows[k].ocf);
         chk(rff, rows[k].rff);
         chk(oci, rows[k].ocf & ~rows[k].msk);
         chk(rfi, rows[k].rff & ~rows[k].msk);
         chk(e1, rows[k].srs);
         clear_flags();
         tx_run = 1'b1;
         wait_for(tlost, 1'b0);
         chk(src, rows[k].osc);
         chk(rfr, 1'b0);
         chk(ocf, rows[k].ocf);
         chk(rff, rows[k].rff);
      end
      // A short outage only regulates.
      tx_run = 1'b0;
      watch(300);
      chk(sr, 1'b1);
      chk(tlost | rfr, 1'b0);
      tx_run = 1'b1;
      cyc(200);
      // Clearing auto-switch during loss forces the input back.
      osc = 1'b0;
      cyc(20);
      tx_run = 1'b0;
      wait_for(tlost, 1'b1);
      clear_flags();
      auto_on = 1'b0;
      cyc(3);
      chk(src | rfr, 1'b0);
      chk(ocf & rff, 1'b1);
      clear_flags();
      cyc(50);
      chk(src | ocf, 1'b0);
      tx_run = 1'b1;
      wait_for(tlost, 1'b0);
      // Auto off: the oscillator centres on reference loss.
      {osc, centre} = 2'h3;
      tx_run = 1'b0;
      wait_for(tlost, 1'b1);
      chk(cen, 1'b1);
      chk(frz, 1'b0);
      tx_run = 1'b1;
      fr_run = 1'b0;
      wait_for(flost, 1'b1);
      wait_for(tlost, 1'b0);
      // Ternary marks alternate legs; then CMI output.
      {osc, data} = 2'h1;
      watch(600);
      chk(sa & sb, 1'b1);
      chk(sc, 1'b1);
      {code_a, dual, data} = 3'h2;
      watch(600);
      chk(so, 1'b1);
      test_done();
   end
endmodule : tb_tcs_tx_clock_switch
